// file: rtl/phy_mode_loopback_reset.sv
// Mode, loopback, media interface selection and reset sequencing of the physical layer.
// Operation
// - Primary media interface is always enabled; nothing can switch it off.
// - Alternate media interface is off after reset, on when software writes one.
// - Transmit clock outputs are off after reset, on when software writes one.
// - Alternate interface active disconnects long internal loopback; host avoids selecting it.
// - Run mode connects media and both ports, passing line states and frames.
// - Reset pin low forces stop mode; initialization runs in stop mode.
// - Writing zero to the run bit enters stop mode.
// - Stop resets filters, counters, clock recovery, flushes buffer, line state unknown.
// - Stop drives invalid symbol pairs with parity and control on enabled ports.
// - Stop sends quiet symbol pairs on the serial transmit output.
// - Port A indicate mux selects receiver, port A, port B or invalid data.
// - Port B indicate mux selects receiver, port A, port B or invalid data.
// - Transmitter mux can route receiver output into the transmitter for repeating.
// - Short loopback feeds transmitter to receiver, ignores serial input, sends quiet.
// - Long loopback feeds transmitter to clock recovery, ignores input, sends quiet.
// - Either internal loopback sends quiet at the transmitter-off level.
// - Both loopbacks selected means long internal loopback applies; with the alternate interface active, short loopback applies.
// - Power-up waits for crystal, locks clock generator, resets all, about 10 ms.
// - Hardware reset starts at reset release, skips crystal wait, lasts about 1 ms.
// - Soft reset bit resets the physical-layer module for about 3 us only.
`timescale 1ns/1ps
module phy_mode_loopback_reset #(
  parameter int POWERUP_CYCLES = phy_mode_pkg::POWERUP_NS / phy_mode_pkg::CLK_PERIOD_NS,
  parameter int HW_RESET_CYCLES = phy_mode_pkg::HW_RESET_NS / phy_mode_pkg::CLK_PERIOD_NS
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  input wire logic powerGood,
  input wire logic refSelectIn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic [7:0] portARequestByte,
  input wire logic portARequestParity,
  input wire logic portARequestControl,
  input wire logic [7:0] portBRequestByte,
  input wire logic portBRequestParity,
  input wire logic portBRequestControl,
  input wire logic [7:0] receiverByte,
  input wire logic receiverParity,
  input wire logic receiverControl,
  output logic [7:0] portAIndicateByte,
  output logic portAIndicateParity,
  output logic portAIndicateControl,
  output logic [7:0] portBIndicateByte,
  output logic portBIndicateParity,
  output logic portBIndicateControl,
  output logic [7:0] transmitterByte,
  output logic transmitterParity,
  output logic transmitterControl,
  output logic primaryMediaEnable,
  output logic altMediaIfEnable,
  output logic transmitClockOutputEnable,
  output logic mediaTxForceQuiet,
  output logic mediaTxOffLevel,
  output logic mediaRxIgnore,
  output logic shortLoopActive,
  output logic longLoopActive,
  output logic crystalWait,
  output logic clockGenLocking,
  output logic allModulesReset,
  output logic phyModuleReset,
  output logic clockRecoveryReset,
  output logic repeatFilterReset,
  output logic smootherReset,
  output logic lineStateCounterReset,
  output logic elasticityFlush,
  output logic lineStateUnknown,
  output logic stopMode
);

  localparam int CRYSTAL_CYCLES = POWERUP_CYCLES - HW_RESET_CYCLES;
  localparam int LOCK_CYCLES = HW_RESET_CYCLES - phy_mode_pkg::CLEAR_CYCLES;

  // Phase lengths must be positive for the sequencer to advance.
  if (LOCK_CYCLES < 1 || CRYSTAL_CYCLES < 1) begin : g_bad_cycles
    $error("Reset phase lengths must be at least one cycle.");
  end

  // Odd parity over control flag and byte.
  function automatic logic oddParity(input logic control, input logic [7:0] data);
    oddParity = ~^{control, data};
  endfunction : oddParity

  // Indicate multiplexer shared by both ports; returns {parity, control, byte}.
  function automatic logic [9:0] indicateSelect(input logic [1:0] sel, input logic [9:0] rx,
                                                input logic [9:0] portA, input logic [9:0] portB);
    logic [9:0] invalid;
    invalid = {oddParity(phy_mode_pkg::PHY_INVALID_CONTROL, phy_mode_pkg::PHY_INVALID_BYTE),
               phy_mode_pkg::PHY_INVALID_CONTROL, phy_mode_pkg::PHY_INVALID_BYTE};
    case (sel)
      phy_mode_pkg::IND_RECEIVER: indicateSelect = rx;
      phy_mode_pkg::IND_PORT_A: indicateSelect = portA;
      phy_mode_pkg::IND_PORT_B: indicateSelect = portB;
      default: indicateSelect = invalid;
    endcase
  endfunction : indicateSelect

  logic rstSync1;
  logic rstSync2;
  logic rst;
  logic pgSync1;
  logic pgSync2;
  logic pgLast;
  logic refSync1;
  logic refSync2;
  logic refLast;
  logic pgRise;
  logic refFall;
  phy_mode_pkg::seq_state_t state;
  logic [31:0] seqCnt;
  logic [9:0] softCnt;
  logic softBusy;
  logic [2:0] modeReg;
  logic [6:0] switchCfg;
  logic dpValid;
  logic dpWrite;
  logic dpMapped;
  logic [7:0] dpAddr;
  logic wrEn;
  logic busAccept;
  logic [31:0] readValue;
  logic [9:0] rxSym;
  logic [9:0] aSym;
  logic [9:0] bSym;
  logic [9:0] invalidSym;

  // Reset pin released through two flops; assertion stays asynchronous.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstSync1 <= 1'b0;
      rstSync2 <= 1'b0;
    end else begin
      rstSync1 <= 1'b1;
      rstSync2 <= rstSync1;
    end
  end
  assign rst = !rstSync2;

  // Supply-good and reference-select pins synchronised; idle levels avoid false edges at release.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      pgSync1 <= 1'b1;
      pgSync2 <= 1'b1;
      pgLast <= 1'b1;
      refSync1 <= 1'b0;
      refSync2 <= 1'b0;
      refLast <= 1'b0;
    end else if (ce) begin
      pgSync1 <= powerGood;
      pgSync2 <= pgSync1;
      pgLast <= pgSync2;
      refSync1 <= refSelectIn;
      refSync2 <= refSync1;
      refLast <= refSync2;
    end
  end
  assign pgRise = pgSync2 && !pgLast;
  assign refFall = !refSync2 && refLast;

  // Reset sequencer: crystal wait, clock generator lock, clear of all modules, ready.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state <= phy_mode_pkg::SEQ_LOCK;
      seqCnt <= 32'h0000_0000;
    end else if (ce) begin
      if (pgRise || refFall) begin
        state <= phy_mode_pkg::SEQ_CRYSTAL;
        seqCnt <= 32'h0000_0000;
      end else begin
        case (state)
          phy_mode_pkg::SEQ_CRYSTAL: begin
            if (seqCnt == 32'(CRYSTAL_CYCLES - 1)) begin
              state <= phy_mode_pkg::SEQ_LOCK;
              seqCnt <= 32'h0000_0000;
            end else begin
              seqCnt <= seqCnt + 32'h0000_0001;
            end
          end
          phy_mode_pkg::SEQ_LOCK: begin
            if (seqCnt == 32'(LOCK_CYCLES - 1)) begin
              state <= phy_mode_pkg::SEQ_CLEAR;
              seqCnt <= 32'h0000_0000;
            end else begin
              seqCnt <= seqCnt + 32'h0000_0001;
            end
          end
          phy_mode_pkg::SEQ_CLEAR: begin
            if (seqCnt == 32'(phy_mode_pkg::CLEAR_CYCLES - 1)) begin
              state <= phy_mode_pkg::SEQ_READY;
              seqCnt <= 32'h0000_0000;
            end else begin
              seqCnt <= seqCnt + 32'h0000_0001;
            end
          end
          default: begin
            state <= phy_mode_pkg::SEQ_READY;
            seqCnt <= 32'h0000_0000;
          end
        endcase
      end
    end
  end

  assign crystalWait = (state == phy_mode_pkg::SEQ_CRYSTAL);
  assign clockGenLocking = (state == phy_mode_pkg::SEQ_LOCK);
  assign allModulesReset = (state == phy_mode_pkg::SEQ_CLEAR);

  // AHB-Lite address phase capture; the bus stalls while the soft reset runs.
  assign hreadyout = ce && !softBusy;
  assign hresp = 1'b0;
  assign busAccept = hsel && hready && htrans[1];
  assign wrEn = dpValid && dpWrite && dpMapped && hready && ce;

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dpValid <= 1'b0;
      dpWrite <= 1'b0;
      dpMapped <= 1'b0;
      dpAddr <= 8'h00;
    end else if (ce && hready) begin
      dpValid <= busAccept;
      dpWrite <= hwrite;
      dpMapped <= (haddr[31:8] == 24'h00_0000);
      dpAddr <= haddr[7:0];
    end
  end

  // Read mux; unmapped addresses read as zero.
  always_comb begin
    readValue = 32'h0000_0000;
    if (haddr[31:8] == 24'h00_0000) begin
      case (haddr[7:0])
        phy_mode_pkg::ADDR_MODE: readValue = {29'h0, modeReg};
        phy_mode_pkg::ADDR_MODE2: readValue = {31'h0, softBusy};
        phy_mode_pkg::ADDR_SWITCH_CFG: readValue = {25'h0, switchCfg};
        phy_mode_pkg::ADDR_ALT_MEDIA: readValue = {31'h0, altMediaIfEnable};
        phy_mode_pkg::ADDR_CLOCK_GEN: readValue = {31'h0, transmitClockOutputEnable};
        phy_mode_pkg::ADDR_STATUS: readValue = {26'h0, longLoopActive, shortLoopActive,
                                                stopMode, softBusy, state};
        default: readValue = 32'h0000_0000;
      endcase
    end
  end

  // Read data registered at the address phase, held through the data phase.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      hrdata <= 32'h0000_0000;
    end else if (ce && busAccept && !hwrite) begin
      hrdata <= readValue;
    end
  end

  // Control registers; a full module clear restores their defaults.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      modeReg <= phy_mode_pkg::MODE_RESET;
      switchCfg <= phy_mode_pkg::SWITCH_CFG_RESET;
      altMediaIfEnable <= phy_mode_pkg::ALT_ENABLE_RESET;
      transmitClockOutputEnable <= phy_mode_pkg::TX_CLOCK_ENABLE_RESET;
    end else if (ce) begin
      if (allModulesReset) begin
        modeReg <= phy_mode_pkg::MODE_RESET;
        switchCfg <= phy_mode_pkg::SWITCH_CFG_RESET;
        altMediaIfEnable <= phy_mode_pkg::ALT_ENABLE_RESET;
        transmitClockOutputEnable <= phy_mode_pkg::TX_CLOCK_ENABLE_RESET;
      end else if (wrEn) begin
        case (dpAddr)
          phy_mode_pkg::ADDR_MODE: modeReg <= hwdata[2:0];
          phy_mode_pkg::ADDR_SWITCH_CFG: switchCfg <= hwdata[6:0];
          phy_mode_pkg::ADDR_ALT_MEDIA:
            altMediaIfEnable <= hwdata[phy_mode_pkg::ALT_ENABLE_BIT];
          phy_mode_pkg::ADDR_CLOCK_GEN:
            transmitClockOutputEnable <= hwdata[phy_mode_pkg::CLKGEN_TX_CLOCK_BIT];
          default: modeReg <= modeReg;
        endcase
      end
    end
  end

  // Soft reset timer: writing one to the soft reset bit holds the physical-layer module.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      softCnt <= 10'h000;
    end else if (ce) begin
      if (allModulesReset) begin
        softCnt <= 10'h000;
      end else if (wrEn && dpAddr == phy_mode_pkg::ADDR_MODE2 &&
                   hwdata[phy_mode_pkg::MODE2_SOFT_RESET_BIT]) begin
        softCnt <= 10'(phy_mode_pkg::SOFT_RESET_CYCLES);
      end else if (softCnt != 10'h000) begin
        softCnt <= softCnt - 10'h001;
      end
    end
  end
  assign softBusy = (softCnt != 10'h000);
  assign phyModuleReset = allModulesReset || softBusy;

  // Stop mode: reset pin, sequencing or a cleared run bit.
  assign stopMode = !modeReg[phy_mode_pkg::MODE_RUN_BIT] ||
    (state != phy_mode_pkg::SEQ_READY);
  assign clockRecoveryReset = stopMode || allModulesReset;
  assign repeatFilterReset = stopMode || phyModuleReset;
  assign smootherReset = stopMode || phyModuleReset;
  assign lineStateCounterReset = stopMode || phyModuleReset;
  assign elasticityFlush = stopMode || phyModuleReset;
  assign lineStateUnknown = stopMode || phyModuleReset;

  // Media interface and loopback selection.
  assign primaryMediaEnable = 1'b1;
  assign longLoopActive = modeReg[phy_mode_pkg::MODE_LONG_LOOP_BIT] &&
    !altMediaIfEnable;
  assign shortLoopActive = modeReg[phy_mode_pkg::MODE_SHORT_LOOP_BIT] && !longLoopActive;
  assign mediaRxIgnore = shortLoopActive || longLoopActive;
  assign mediaTxOffLevel = shortLoopActive || longLoopActive;
  assign mediaTxForceQuiet = stopMode || shortLoopActive || longLoopActive;

  assign rxSym = {receiverParity, receiverControl, receiverByte};
  assign aSym = {portARequestParity, portARequestControl, portARequestByte};
  assign bSym = {portBRequestParity, portBRequestControl, portBRequestByte};
  assign invalidSym = indicateSelect(phy_mode_pkg::IND_INVALID, rxSym, aSym, bSym);

  // Indicate and transmitter paths; disabled ports drive zero, stop forces invalid pairs on enabled indicate ports.
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      {portAIndicateParity, portAIndicateControl, portAIndicateByte} <= 10'h000;
      {portBIndicateParity, portBIndicateControl, portBIndicateByte} <= 10'h000;
      {transmitterParity, transmitterControl, transmitterByte} <= 10'h000;
    end else if (ce) begin
      if (!switchCfg[phy_mode_pkg::SW_A_ENABLE_BIT]) begin
        {portAIndicateParity, portAIndicateControl, portAIndicateByte} <= 10'h000;
      end else if (stopMode) begin
        {portAIndicateParity, portAIndicateControl, portAIndicateByte} <= invalidSym;
      end else begin
        {portAIndicateParity, portAIndicateControl, portAIndicateByte} <=
          indicateSelect(switchCfg[phy_mode_pkg::SW_A_SEL_LSB +: 2], rxSym, aSym, bSym);
      end
      if (!switchCfg[phy_mode_pkg::SW_B_ENABLE_BIT]) begin
        {portBIndicateParity, portBIndicateControl, portBIndicateByte} <= 10'h000;
      end else if (stopMode) begin
        {portBIndicateParity, portBIndicateControl, portBIndicateByte} <= invalidSym;
      end else begin
        {portBIndicateParity, portBIndicateControl, portBIndicateByte} <=
          indicateSelect(switchCfg[phy_mode_pkg::SW_B_SEL_LSB +: 2], rxSym, aSym, bSym);
      end
      {transmitterParity, transmitterControl, transmitterByte} <=
        switchCfg[phy_mode_pkg::SW_TX_REPEAT_BIT] ? rxSym : aSym;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (rst || !ce);

  sequence s_soft_write;
    wrEn && dpAddr == phy_mode_pkg::ADDR_MODE2 && hwdata[phy_mode_pkg::MODE2_SOFT_RESET_BIT];
  endsequence
  sequence s_soft_hold;
    (phyModuleReset && !hreadyout) [*8];
  endsequence

  a_primary_on: assert property (primaryMediaEnable)
    else $error("Primary media interface disabled.");
  a_alt_write: assert property (wrEn && dpAddr == phy_mode_pkg::ADDR_ALT_MEDIA && !allModulesReset
    |=> altMediaIfEnable == $past(hwdata[0]))
    else $error("Alternate interface enable did not follow the write.");
  a_clear_defaults: assert property ($fell(allModulesReset)
    |-> !altMediaIfEnable && !transmitClockOutputEnable)
    else $error("Enables not cleared by module reset.");
  a_long_alt_off: assert property (altMediaIfEnable |-> !longLoopActive)
    else $error("Long loopback active with alternate interface.");
  a_run_connect: assert property (!stopMode && !shortLoopActive && !longLoopActive
    |-> !mediaTxForceQuiet && !mediaRxIgnore)
    else $error("Run mode not connected to media.");
  a_seq_stop: assert property (state != phy_mode_pkg::SEQ_READY |-> stopMode)
    else $error("Not in stop mode during initialization.");
  a_run_clear: assert property (wrEn && dpAddr == phy_mode_pkg::ADDR_MODE && !hwdata[0]
    |=> stopMode)
    else $error("Run bit cleared without stop mode.");
  a_stop_resets: assert property (stopMode |-> clockRecoveryReset && elasticityFlush &&
    lineStateUnknown && repeatFilterReset && mediaTxForceQuiet)
    else $error("Stop mode resets missing.");
  a_stop_invalid: assert property (stopMode && switchCfg[phy_mode_pkg::SW_A_ENABLE_BIT]
    |=> portAIndicateByte == phy_mode_pkg::PHY_INVALID_BYTE && portAIndicateControl)
    else $error("Port A not invalid in stop mode.");
  a_loop_quiet: assert property (shortLoopActive || longLoopActive
    |-> mediaTxForceQuiet && mediaTxOffLevel && mediaRxIgnore)
    else $error("Loopback not quiet at off level.");
  a_loop_priority: assert property (modeReg[1] && modeReg[2] && !altMediaIfEnable
    |-> longLoopActive && !shortLoopActive)
    else $error("Long loopback lost priority.");
  a_indicate_b: assert property (!stopMode && switchCfg[5] && switchCfg[1:0] == 2'h2
    |=> portAIndicateByte == $past(portBRequestByte))
    else $error("Port A indicate mux wrong.");
  a_crystal_len: assert property ($fell(crystalWait) && !pgRise
    |-> $past(seqCnt) == 32'(CRYSTAL_CYCLES - 1) && clockGenLocking)
    else $error("Crystal wait length wrong.");
  a_lock_len: assert property ($rose(allModulesReset)
    |-> $past(seqCnt) == 32'(LOCK_CYCLES - 1))
    else $error("Hardware reset lock phase length wrong.");
  a_soft_hold: assert property (s_soft_write |=> s_soft_hold)
    else $error("Soft reset did not hold the bus.");

endmodule : phy_mode_loopback_reset

// file: shared/phy_mode_pkg.sv
// Constants and types shared by the mode, loopback and reset control block.
package phy_mode_pkg;

  // Register byte addresses on the AHB-Lite slave.
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_MODE2 = 8'h04;
  localparam logic [7:0] ADDR_SWITCH_CFG = 8'h08;
  localparam logic [7:0] ADDR_ALT_MEDIA = 8'h0C;
  localparam logic [7:0] ADDR_CLOCK_GEN = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;

  // Field positions.
  localparam int MODE_RUN_BIT = 0;
  localparam int MODE_SHORT_LOOP_BIT = 1;
  localparam int MODE_LONG_LOOP_BIT = 2;
  localparam int MODE2_SOFT_RESET_BIT = 0;
  localparam int SW_A_SEL_LSB = 0;
  localparam int SW_B_SEL_LSB = 2;
  localparam int SW_TX_REPEAT_BIT = 4;
  localparam int SW_A_ENABLE_BIT = 5;
  localparam int SW_B_ENABLE_BIT = 6;
  localparam int ALT_ENABLE_BIT = 0;
  localparam int CLKGEN_TX_CLOCK_BIT = 0;

  // Values after reset.
  localparam logic [2:0] MODE_RESET = 3'h0;
  localparam logic [6:0] SWITCH_CFG_RESET = 7'h60;
  localparam logic ALT_ENABLE_RESET = 1'b0;
  localparam logic TX_CLOCK_ENABLE_RESET = 1'b0;

  // Times in nanoseconds and the clock period.
  localparam int CLK_PERIOD_NS = 5;
  localparam int POWERUP_NS = 10_000_000;
  localparam int HW_RESET_NS = 1_000_000;
  localparam int SOFT_RESET_NS = 3_000;
  localparam int SOFT_RESET_CYCLES = SOFT_RESET_NS / CLK_PERIOD_NS;
  localparam int CLEAR_CYCLES = 16;

  // Symbol pair driven while no valid data may pass: invalid code, unknown line state.
  localparam logic [7:0] PHY_INVALID_BYTE = 8'h37;
  localparam logic PHY_INVALID_CONTROL = 1'b1;

  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;

  typedef enum logic [1:0] {
    IND_RECEIVER = 2'h0,
    IND_PORT_A = 2'h1,
    IND_PORT_B = 2'h2,
    IND_INVALID = 2'h3
  } ind_sel_t;

  typedef enum logic [1:0] {
    SEQ_CRYSTAL = 2'h0,
    SEQ_LOCK = 2'h1,
    SEQ_CLEAR = 2'h3,
    SEQ_READY = 2'h2
  } seq_state_t;

endpackage : phy_mode_pkg

// file: verif/media_transceiver_model.sv
// Behavioural media transceiver that feeds received symbol pairs into the block.
`timescale 1ns/1ps
module media_transceiver_model (
  input wire logic clk,
  input wire logic rst_n,
  output logic [7:0] receiverByte,
  output logic receiverParity,
  output logic receiverControl
);
  logic [7:0] count;

  // A new symbol pair every cycle, so a stale or repeated sample always shows.
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count <= 8'h00;
    end else begin
      count <= count + 8'h0B;
    end
  end

  // Control follows the low bit and parity is odd over control and byte.
  assign receiverByte = count;
  assign receiverControl = count[0];
  assign receiverParity = ~^{count[0], count};
endmodule : media_transceiver_model

// file: verif/testbench.sv
// Self-checking bench for the mode, loopback and reset control block.
`timescale 1ns/1ps
module testbench;
  localparam int PU = 200;
  localparam int HW = 60;
  logic clk, rst_n, ce, powerGood, refSelectIn, hsel, hwrite, hreadyout, hresp;
  logic [1:0] htrans;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [9:0] reqA, reqB, rx;
  logic [7:0] portARequestByte, portBRequestByte, receiverByte;
  logic portARequestParity, portARequestControl, portBRequestParity, portBRequestControl;
  logic receiverParity, receiverControl;
  logic [7:0] portAIndicateByte, portBIndicateByte, transmitterByte;
  logic portAIndicateParity, portAIndicateControl, portBIndicateParity, portBIndicateControl;
  logic transmitterParity, transmitterControl, primaryMediaEnable, altMediaIfEnable;
  logic transmitClockOutputEnable, mediaTxForceQuiet, mediaTxOffLevel, mediaRxIgnore;
  logic shortLoopActive, longLoopActive, crystalWait, clockGenLocking, allModulesReset;
  logic phyModuleReset, clockRecoveryReset, repeatFilterReset, smootherReset;
  logic lineStateCounterReset, elasticityFlush, lineStateUnknown, stopMode;
  int error_cnt = 0;
  int check_count = 0;
  wire [9:0] indA = {portAIndicateControl, portAIndicateParity, portAIndicateByte};
  wire [9:0] indB = {portBIndicateControl, portBIndicateParity, portBIndicateByte};
  wire [9:0] txSym = {transmitterControl, transmitterParity, transmitterByte};
  wire [5:0] stopResets = {clockRecoveryReset, repeatFilterReset, smootherReset,
    lineStateCounterReset, elasticityFlush, lineStateUnknown};
  wire [9:0] invSym = {phy_mode_pkg::PHY_INVALID_CONTROL,
    ~^{phy_mode_pkg::PHY_INVALID_CONTROL, phy_mode_pkg::PHY_INVALID_BYTE},
    phy_mode_pkg::PHY_INVALID_BYTE};
  assign {portARequestControl, portARequestParity, portARequestByte} = reqA;
  assign {portBRequestControl, portBRequestParity, portBRequestByte} = reqB;

  phy_mode_loopback_reset #(.POWERUP_CYCLES(PU), .HW_RESET_CYCLES(HW))
    u_phy_mode_loopback_reset (.hsize(3'h2), .hready(hreadyout), .*);
  media_transceiver_model u_media_transceiver_model (.*);

  // Free-running 200 MHz clock.
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic settle();
    @(posedge clk);
    #1;
  endtask : settle

  // One single-word transfer; waits on hready in both phases, read data taken at the end.
  task automatic bus(input logic wr, input logic [7:0] addr, input logic [31:0] wd);
    @(posedge clk);
    htrans <= phy_mode_pkg::HTRANS_NONSEQ;
    haddr <= {24'h000000, addr};
    hwrite <= wr;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    htrans <= 2'h0;
    hwdata <= wd;
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask : bus

  task automatic rdchk(input logic [7:0] addr, input logic [31:0] exp);
    bus(1'b0, addr, 32'h0);
    check(rd, exp);
  endtask : rdchk

  // Counts cycles until the sequencer has left every reset phase.
  task automatic seq_done(output int n, output logic sawXtal);
    n = 0;
    sawXtal = 1'b0;
    while ((crystalWait | clockGenLocking | allModulesReset) !== 1'b0 && n < 5000) begin
      sawXtal = sawXtal | crystalWait;
      settle();
      n++;
    end
  endtask : seq_done

  function automatic logic [9:0] pick(input int s);
    return s == 0 ? rx : (s == 1 ? 10'h1A5 : (s == 2 ? 10'h25A : invSym));
  endfunction : pick

  task automatic t_defaults();
    int n;
    logic x;
    seq_done(n, x);
    check(n >= HW - 2 && n <= HW + 4, 1);
    check({hresp, primaryMediaEnable}, 2'b01);
    check({altMediaIfEnable, transmitClockOutputEnable}, 2'b00);
    check(stopMode, 1'b1);
    check({indA, indB}, {invSym, invSym});
    check({mediaTxForceQuiet, stopResets}, 7'h7F);
    rdchk(phy_mode_pkg::ADDR_SWITCH_CFG, 32'h60);
    rdchk(phy_mode_pkg::ADDR_ALT_MEDIA, 32'h0);
    rdchk(phy_mode_pkg::ADDR_CLOCK_GEN, 32'h0);
    rdchk(8'h40, 32'h0);
    rdchk(phy_mode_pkg::ADDR_STATUS, 32'h0A);
  endtask : t_defaults

  task automatic t_run_switch();
    bus(1'b1, phy_mode_pkg::ADDR_MODE, 32'h1);
    settle();
    check({stopMode, stopResets, mediaTxForceQuiet}, 8'h00);
    for (int s = 0; s < 4; s++) begin
      bus(1'b1, phy_mode_pkg::ADDR_SWITCH_CFG, s == 0 ? 32'h60 : 32'h70 | s | ((4 - s) << 2));
      reqA <= 10'h1A5;
      reqB <= 10'h25A;
      @(posedge clk);
      @(posedge clk);
      rx = {receiverControl, receiverParity, receiverByte};
      #1;
      check(indA, pick(s));
      check(indB, pick((4 - s) % 4));
      check(txSym, s == 0 ? reqA : rx);
    end
    bus(1'b1, phy_mode_pkg::ADDR_MODE, 32'h0);
    settle();
    check({stopMode, mediaTxForceQuiet}, 2'b11);
  endtask : t_run_switch

  task automatic t_loopbacks();
    for (int m = 2; m < 8; m += 2) begin
      bus(1'b1, phy_mode_pkg::ADDR_MODE, m | 1);
      settle();
      check(shortLoopActive, m == 2);
      check(longLoopActive, m != 2);
      check({mediaTxForceQuiet, mediaRxIgnore, mediaTxOffLevel}, 3'h7);
    end
    bus(1'b1, phy_mode_pkg::ADDR_MODE, 32'h1);
    settle();
    check({mediaTxForceQuiet, mediaTxOffLevel, longLoopActive}, 3'h0);
    // Clock enable low must freeze the repeat path while the model keeps changing.
    @(posedge clk);
    ce <= 1'b0;
    #1 rx = txSym;
    repeat (3) settle();
    check({hreadyout, txSym}, {1'b0, rx});
    @(posedge clk);
    ce <= 1'b1;
  endtask : t_loopbacks

  task automatic t_alt_soft();
    int n;
    // The model stays connected on both interfaces while the alternate one is on.
    bus(1'b1, phy_mode_pkg::ADDR_ALT_MEDIA, 32'h1);
    bus(1'b1, phy_mode_pkg::ADDR_CLOCK_GEN, 32'h1);
    bus(1'b1, phy_mode_pkg::ADDR_MODE, 32'h5);
    settle();
    check({altMediaIfEnable, transmitClockOutputEnable}, 2'b11);
    check({longLoopActive, primaryMediaEnable}, 2'b01);
    bus(1'b1, phy_mode_pkg::ADDR_MODE2, 32'h1);
    settle();
    check({phyModuleReset, hreadyout, allModulesReset}, 3'b100);
    n = 1;
    while (hreadyout !== 1'b1 && n < 2000) begin
      settle();
      n++;
    end
    check(n >= phy_mode_pkg::SOFT_RESET_CYCLES - 4, 1);
    check(n <= phy_mode_pkg::SOFT_RESET_CYCLES + 4, 1);
    rdchk(phy_mode_pkg::ADDR_MODE, 32'h5);
  endtask : t_alt_soft

  task automatic t_resets();
    int n;
    logic x;
    @(posedge clk);
    powerGood <= 1'b1;
    repeat (8) settle();
    check(crystalWait, 1'b1);
    seq_done(n, x);
    check(n >= PU - 12 && n <= PU - 4, 1);
    // The host gives power-up its full wait, then always applies the reset pin.
    repeat (PU) @(posedge clk);
    rst_n <= 1'b0;
    #1;
    check(stopMode, 1'b1);
    @(posedge clk);
    rst_n <= 1'b1;
    seq_done(n, x);
    check({x, n >= HW - 2 && n <= HW + 4}, 2'b01);
    rdchk(phy_mode_pkg::ADDR_MODE, 32'h0);
    refSelectIn <= 1'b0;
    repeat (8) settle();
    check(crystalWait, 1'b1);
    seq_done(n, x);
    check({x, n >= PU - 12 && n <= PU - 4}, 2'b11);
  endtask : t_resets

  task automatic final_report();
    $display("checks %0d mismatches %0d", check_count, error_cnt);
    if (error_cnt == 0 && check_count > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : final_report

  // Cuts a hang short well beyond the expected run length.
  initial begin
    #100000;
    error_cnt++;
    final_report();
  end

  // Main sequence: pin reset, then each scenario in turn.
  initial begin
    rst_n = 1'b0;
    {ce, powerGood, refSelectIn, hsel, hwrite, htrans, haddr, hwdata} = {4'b1011, 67'h0};
    {reqA, reqB} = 20'h0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_defaults();
    t_run_switch();
    t_loopbacks();
    t_alt_soft();
    t_resets();
    final_report();
  end
endmodule : testbench
